// ==== hdl/eec_counter.v ====
// edge event counter with load value, target match and wishbone registers
// assumes a classic wishbone master on clk_i and upstream logic on clk_i
// count and reload levels arrive already on clk_i, so no synchroniser
// ce_i low holds every flop, bus answer included
//
// The register addresses and the Wishbone register port were left to the implementer.
`timescale 1ns/1ps
`include "eec_defines.vh"

module eec_counter #(
   parameter [13:0] LOAD_INIT = `EEC_LOAD_RST, // load value after reset
   parameter [13:0] TARGET_INIT = `EEC_TARGET_RST // target after reset
) (
   input wire clk_i, // system clock
   input wire rst_i, // synchronous reset, high
   input wire ce_i, // clock enable, low freezes all state
   input wire wb_cyc_i, // bus cycle
   input wire wb_stb_i, // bus strobe
   input wire wb_we_i, // write enable
   input wire [7:0] wb_adr_i, // byte address
   input wire [3:0] wb_sel_i, // byte lanes
   input wire [31:0] wb_dat_i, // write data
   output reg [31:0] wb_dat_o, // read data
   output reg wb_ack_o, // acknowledge
   input wire count_pulse_in_i, // count input level
   input wire count_err_i, // count input carries error
   input wire reload_i, // reload input level
   input wire reload_err_i, // reload input carries error
   output reg match_o, // count matched target
   output reg [13:0] count_o // current count
);

   // merge write lanes into a 14 bit field and clamp to range
   function [13:0] wr_val;
      input [13:0] old;
      input [31:0] dat;
      input [3:0] sel;
      reg [13:0] v;
      begin
         v = old;
         if (sel[0]) begin
            v[7:0] = dat[7:0];
         end
         if (sel[1]) begin
            v[13:8] = dat[13:8];
         end
         if (v > `EEC_CNT_MAX) begin
            v = `EEC_CNT_MAX;
         end
         wr_val = v;
      end
   endfunction

   // true when an input moved in the selected way
   function edge_hit;
      input cur;
      input prev;
      input [1:0] mode;
      begin
         case (mode)
            `EEC_EDGE_BOTH: edge_hit = cur ^ prev;
            `EEC_EDGE_RISE: edge_hit = cur & ~prev;
            `EEC_EDGE_FALL: edge_hit = ~cur & prev;
            default: edge_hit = 1'b0;
         endcase
      end
   endfunction

   // one-hot register select from a byte address, shared by write and read
   function [4:0] reg_hit;
      input [7:0] adr;
      begin
         case (adr)
            `EEC_OFF_CTRL: reg_hit = 5'h01;
            `EEC_OFF_TARGET: reg_hit = 5'h02;
            `EEC_OFF_LOAD: reg_hit = 5'h04;
            `EEC_OFF_COUNT: reg_hit = 5'h08;
            `EEC_OFF_STATUS: reg_hit = 5'h10;
            default: reg_hit = 5'h00;
         endcase
      end
   endfunction

   // one count step with wrap at both ends
   function [13:0] cnt_step;
      input [13:0] cur;
      input down;
      begin
         if (down) begin
            if (cur == 14'h0000) begin
               cnt_step = `EEC_CNT_MAX;
            end else begin
               cnt_step = cur - 14'h0001;
            end
         end else begin
            if (cur >= `EEC_CNT_MAX) begin
               cnt_step = 14'h0000;
            end else begin
               cnt_step = cur + 14'h0001;
            end
         end
      end
   endfunction

   reg [4:0] ctrl_ff;
   reg [13:0] target_ff;
   reg [13:0] load_ff;
   reg [13:0] count_ff;
   reg match_ff;
   reg [1:0] prev_ff;
   reg ack_ff;
   reg [31:0] rdat_ff;

   reg [4:0] nxt_ctrl;
   reg [13:0] nxt_target;
   reg [13:0] nxt_load;
   reg [13:0] nxt_count;
   reg nxt_match;
   reg nxt_ack;
   reg [31:0] nxt_rdat;

   wire bus_req;
   wire bus_wr;
   wire dir_down;
   wire [1:0] cnt_mode;
   wire [1:0] rld_mode;
   wire latch_en;
   wire cnt_event;
   wire rld_event;
   wire [1:0] in_lvl;

   assign bus_req = wb_cyc_i & wb_stb_i;
   assign bus_wr = bus_req & wb_we_i & ack_ff;
   assign dir_down = ctrl_ff[`EEC_CTRL_DIR];
   assign cnt_mode = ctrl_ff[`EEC_CTRL_EDGE_HI:`EEC_CTRL_EDGE_LO];
   assign latch_en = ctrl_ff[`EEC_CTRL_LATCH];
   // reload edge: 0 rising, 1 falling
   assign rld_mode = ctrl_ff[`EEC_CTRL_RLD_EDGE] ? `EEC_EDGE_FALL
                                                 : `EEC_EDGE_RISE;

   // qualified events, each masked only by its own error
   assign cnt_event = edge_hit(count_pulse_in_i, prev_ff[0], cnt_mode)
                      & ~count_err_i;
   assign rld_event = edge_hit(reload_i, prev_ff[1], rld_mode)
                      & ~reload_err_i;

   // configuration writes
   always @* begin
      nxt_ctrl = ctrl_ff;
      nxt_target = target_ff;
      nxt_load = load_ff;
      if (bus_wr) begin
         case (reg_hit(wb_adr_i))
            5'h01: begin
               if (wb_sel_i[0]) begin
                  nxt_ctrl = wb_dat_i[4:0];
               end
            end
            5'h02: begin
               nxt_target = wr_val(target_ff, wb_dat_i, wb_sel_i);
            end
            5'h04: begin
               nxt_load = wr_val(load_ff, wb_dat_i, wb_sel_i);
            end
            default: begin
               nxt_ctrl = ctrl_ff;
            end
         endcase
      end
   end

   // count update
   always @* begin
      nxt_count = count_ff;
      if (rld_event) begin
         nxt_count = load_ff;
      end else if (cnt_event) begin
         // wrap handled in cnt_step
         nxt_count = cnt_step(count_ff, dir_down);
      end
   end

   // match follows count one cycle later; a reload edge clears it unless reload_err_i masks that edge
   always @* begin
      if (rld_event) begin
         nxt_match = 1'b0;
      end else if (latch_en) begin
         nxt_match = match_ff | (count_ff == target_ff);
      end else begin
         nxt_match = (count_ff == target_ff);
      end
   end

   // bus answer: ack one cycle after request, dropped the next
   always @* begin
      nxt_ack = bus_req & ~ack_ff;
      nxt_rdat = 32'h00000000;
      case (reg_hit(wb_adr_i))
         5'h01: begin
            nxt_rdat[4:0] = ctrl_ff;
         end
         5'h02: begin
            nxt_rdat[13:0] = target_ff;
         end
         5'h04: begin
            nxt_rdat[13:0] = load_ff;
         end
         5'h08: begin
            nxt_rdat[13:0] = count_ff;
         end
         5'h10: begin
            nxt_rdat[`EEC_STAT_MATCH] = match_ff;
            nxt_rdat[`EEC_STAT_CNT_ERR] = count_err_i;
            nxt_rdat[`EEC_STAT_RLD_ERR] = reload_err_i;
         end
         default: begin
            nxt_rdat = 32'h00000000;
         end
      endcase
   end

   // control register
   always @(posedge clk_i) begin
      if (rst_i) begin
         ctrl_ff <= `EEC_CTRL_RST;
      end else if (ce_i) begin
         ctrl_ff <= nxt_ctrl;
      end
   end

   // target register
   always @(posedge clk_i) begin
      if (rst_i) begin
         target_ff <= TARGET_INIT;
      end else if (ce_i) begin
         target_ff <= nxt_target;
      end
   end

   // load register
   always @(posedge clk_i) begin
      if (rst_i) begin
         load_ff <= LOAD_INIT;
      end else if (ce_i) begin
         load_ff <= nxt_load;
      end
   end

   // count, starts from the load value
   always @(posedge clk_i) begin
      if (rst_i) begin
         count_ff <= LOAD_INIT;
      end else if (ce_i) begin
         count_ff <= nxt_count;
      end
   end

   // match flag
   always @(posedge clk_i) begin
      if (rst_i) begin
         match_ff <= 1'b0;
      end else if (ce_i) begin
         match_ff <= nxt_match;
      end
   end

   // level history, one flop per input
   // reset low, so a level held high at release counts as a rise
   assign in_lvl = {reload_i, count_pulse_in_i};
   genvar gi;
   generate
      for (gi = 0; gi < 2; gi = gi + 1) begin : g_hist
         always @(posedge clk_i) begin
            if (rst_i) begin
               prev_ff[gi] <= 1'b0;
            end else if (ce_i) begin
               prev_ff[gi] <= in_lvl[gi];
            end
         end
      end
   endgenerate

   // bus acknowledge
   always @(posedge clk_i) begin
      if (rst_i) begin
         ack_ff <= 1'b0;
      end else if (ce_i) begin
         ack_ff <= nxt_ack;
      end
   end

   // read data, captured with the acknowledge
   always @(posedge clk_i) begin
      if (rst_i) begin
         rdat_ff <= 32'h00000000;
      end else if (ce_i) begin
         if (nxt_ack) begin
            rdat_ff <= nxt_rdat;
         end
      end
   end

   // outputs straight from flops; no error output exists
   always @* begin
      wb_ack_o = ack_ff;
   end

   always @* begin
      wb_dat_o = rdat_ff;
   end

   always @* begin
      match_o = match_ff;
   end

   always @* begin
      count_o = count_ff;
   end

endmodule // eec_counter

// ==== include/eec_defines.vh ====
// register map and field layout of the edge event counter
// included by the counter design; definitions only
`ifndef EEC_DEFINES_VH
`define EEC_DEFINES_VH

// register byte offsets
`define EEC_OFF_CTRL 8'h00
`define EEC_OFF_TARGET 8'h04
`define EEC_OFF_LOAD 8'h08
`define EEC_OFF_COUNT 8'h0c
`define EEC_OFF_STATUS 8'h10

// count range
`define EEC_CNT_W 14
`define EEC_CNT_MAX 14'h270f

// control fields
`define EEC_CTRL_DIR 0
`define EEC_CTRL_EDGE_LO 1
`define EEC_CTRL_EDGE_HI 2
`define EEC_CTRL_RLD_EDGE 3
`define EEC_CTRL_LATCH 4

// count edge encodings
`define EEC_EDGE_BOTH 2'h0
`define EEC_EDGE_RISE 2'h1
`define EEC_EDGE_FALL 2'h2

// status fields
`define EEC_STAT_MATCH 0
`define EEC_STAT_CNT_ERR 1
`define EEC_STAT_RLD_ERR 2

// reset values
`define EEC_CTRL_RST 5'h00
`define EEC_TARGET_RST 14'h0000
`define EEC_LOAD_RST 14'h0000

`endif

// ==== sim/eec_checker.sv ====
// port assertions for eec_counter
// bound to every eec_counter instance; one clock domain
`timescale 1ns/1ps
module eec_checker (
   input wire clk_i, // clock
   input wire rst_i, // reset
   input wire ce_i, // enable
   input wire wb_cyc_i, // cycle
   input wire wb_stb_i, // strobe
   input wire wb_ack_o, // ack
   input wire count_err_i, // count error
   input wire reload_i, // reload
   input wire reload_err_i, // reload error
   input wire match_o, // match
   input wire [13:0] count_o // count
);
   reg [13:0] last_ff;
   wire [13:0] up_v = (last_ff == 14'h270f) ? 14'h0 : last_ff + 14'h1;
   wire [13:0] dn_v = (last_ff == 14'h0) ? 14'h270f : last_ff - 14'h1;
   // count moved other than one step
   wire jump = count_o != last_ff && count_o != up_v && count_o != dn_v;
   always @(posedge clk_i) begin
      last_ff <= count_o;
   end
   default clocking @(posedge clk_i); endclocking
   default disable iff (rst_i);
   a_ack_once: assert property (wb_ack_o |=> !wb_ack_o)
      else $error("ack too long");
   a_ack_next: assert property (wb_cyc_i && wb_stb_i && ce_i && !wb_ack_o |=> wb_ack_o)
      else $error("ack missing");
   a_count_range: assert property (count_o <= 14'h270f)
      else $error("count out of range");
   a_count_frozen: assert property (count_err_i && $stable(reload_i) |=> $stable(count_o))
      else $error("count moved during error");
   a_reload_blocked: assert property (reload_err_i |=> !jump)
      else $error("reload during error");
   a_jump_cause: assert property (jump |-> $past(reload_i) != $past(reload_i, 2)
      && !$past(reload_err_i)) else $error("jump without reload");
   a_jump_clear: assert property (jump |-> !match_o)
      else $error("match kept on reload");
   a_match_keep: assert property (match_o && $stable(count_o) && $stable(reload_i)
      && !wb_cyc_i && !$past(wb_cyc_i) |=> match_o) else $error("match dropped");
endmodule // eec_checker
bind eec_counter eec_checker u_chk (.*);

// ==== sim/eec_upstream.sv ====
// upstream logic model driving count and reload lines
// tasks called by the bench; every change follows a rising clk_i
`timescale 1ns/1ps
module eec_upstream (
   input wire clk_i, // clock
   output reg cnt_o, // count level
   output reg cnt_err_o, // count error
   output reg rld_o, // reload level
   output reg rld_err_o // reload error
);
   initial {cnt_o, cnt_err_o, rld_o, rld_err_o} = 4'h0;
   // n toggles, gap idle cycles after each
   task toggle(input int n, input int gap);
      repeat (n) begin
         @(posedge clk_i);
         cnt_o <= ~cnt_o;
         repeat (gap) @(posedge clk_i);
      end
   endtask
   task set_lines(input logic r, input logic ce, input logic re);
      @(posedge clk_i);
      rld_o <= r;
      cnt_err_o <= ce;
      rld_err_o <= re;
   endtask
endmodule // eec_upstream

// ==== sim/testbench.sv ====
// self-checking bench for eec_counter
// bus driven here, counter inputs through eec_upstream
`timescale 1ns/1ps
module testbench;
   reg clk_i = 1'b0;
   reg rst_i = 1'b1;
   reg cyc = 1'b0;
   reg ce = 1'b1;
   reg we = 1'b0;
   reg [7:0] adr = 8'h0;
   reg [31:0] wdat = 32'h0;
   reg [31:0] rd_q;
   reg [13:0] exp_c;
   wire [31:0] rdat;
   wire [13:0] count;
   wire ack, cnt, cnt_err, rld, rld_err, match;
   int err_count = 0;
   int n_checks = 0;
   int i;
   always #5 clk_i = ~clk_i;
   eec_upstream up (.clk_i(clk_i), .cnt_o(cnt), .cnt_err_o(cnt_err), .rld_o(rld),
      .rld_err_o(rld_err));
   eec_counter DUT (.clk_i(clk_i), .rst_i(rst_i), .ce_i(ce), .wb_cyc_i(cyc), .wb_stb_i(cyc),
      .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hf), .wb_dat_i(wdat), .wb_dat_o(rdat),
      .wb_ack_o(ack), .count_pulse_in_i(cnt), .count_err_i(cnt_err), .reload_i(rld),
      .reload_err_i(rld_err), .match_o(match), .count_o(count));
   task tally_and_finish;
      $display("checks %0d errors %0d", n_checks, err_count);
      if (err_count == 0 && n_checks > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask
   task chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
      n_checks++;
      if (seen !== exp) begin
         err_count++;
         $display("wrong value %s exp %h seen %h", nm, exp, seen);
      end
   endtask
   task bus(input logic w, input logic [7:0] a, input logic [31:0] d);
      int t;
      t = 0;
      @(posedge clk_i);
      cyc <= 1'b1;
      we <= w;
      adr <= a;
      wdat <= d;
      do begin
         @(posedge clk_i);
         t++;
      end while (ack !== 1'b1 && t < 50);
      rd_q = rdat;
      cyc <= 1'b0;
      if (t >= 50) begin
         err_count++;
         tally_and_finish;
      end
   endtask
   task rdc(input string nm, input logic [7:0] a, input logic [31:0] exp);
      bus(1'b0, a, 32'h0);
      chk(nm, rd_q, exp);
   endtask
   task settle;
      repeat (3) @(negedge clk_i);
   endtask
   function automatic [13:0] dn(input [13:0] x);
      dn = (x == 14'h0) ? 14'h270f : x - 14'h1;
   endfunction
   initial begin
      repeat (8) @(posedge clk_i);
      rst_i <= 1'b0;
      settle;
      chk("count", count, 32'h0);
      rdc("status", 8'h10, 32'h1);
      rdc("unmapped", 8'h14, 32'h0);
      bus(1'b1, 8'h04, 32'hffff);
      rdc("target", 8'h04, 32'h270f);
      bus(1'b1, 8'h08, 32'h270e);
      bus(1'b1, 8'h0c, 32'h5);
      up.set_lines(1'b1, 1'b0, 1'b0);
      settle;
      chk("reload", count, 32'h270e);
      up.toggle(1, 0);
      settle;
      chk("match", match, 32'h1);
      up.toggle(1, 0);
      settle;
      rdc("count", 8'h0c, 32'h0);
      chk("match", match, 32'h0);
      // down mode, edge codes both, rising, falling
      exp_c = 14'h0;
      for (i = 0; i < 3; i++) begin
         bus(1'b1, 8'h00, 1 + 2 * i);
         up.toggle(2, 3);
         settle;
         exp_c = dn(exp_c);
         if (i == 0)
            exp_c = dn(exp_c);
         chk("down", count, exp_c);
      end
      bus(1'b1, 8'h04, 32'h270b);
      bus(1'b1, 8'h00, 32'h11);
      up.toggle(1, 0);
      up.toggle(1, 0);
      settle;
      chk("latched", match, 32'h1);
      up.set_lines(1'b1, 1'b1, 1'b0);
      up.toggle(1, 0);
      settle;
      rdc("count", 8'h0c, 32'h270a);
      rdc("status", 8'h10, 32'h3);
      bus(1'b1, 8'h00, 32'h19);
      up.set_lines(1'b0, 1'b1, 1'b0);
      settle;
      chk("reload", count, 32'h270e);
      chk("match", match, 32'h0);
      up.set_lines(1'b1, 1'b0, 1'b1);
      up.set_lines(1'b0, 1'b0, 1'b1);
      up.toggle(1, 0);
      settle;
      chk("count", count, 32'h270d);
      up.set_lines(1'b1, 1'b1, 1'b1);
      up.set_lines(1'b0, 1'b1, 1'b1);
      up.toggle(1, 0);
      up.set_lines(1'b1, 1'b0, 1'b0);
      settle;
      chk("count", count, 32'h270d);
      up.set_lines(1'b0, 1'b0, 1'b0);
      settle;
      chk("reload", count, 32'h270e);
      // clock enable low holds count and input history
      @(posedge clk_i);
      ce <= 1'b0;
      up.toggle(1, 0);
      settle;
      chk("frozen", count, 32'h270e);
      @(posedge clk_i);
      ce <= 1'b1;
      settle;
      chk("resumed", count, 32'h270d);
      tally_and_finish;
   end
endmodule // testbench
